// [src/asr_ctrl.sv]
// asr_ctrl: clocked controller driving an asynchronous 128k x 8 static memory.
// assumes the memory pins are wired directly, data_io resolved by the bench.
// limitation: one access in flight; every read pays a bus turnaround.
// no pin is decoded combinationally, so select and strobe cannot glitch.
`timescale 1ns/1ps
module asr_ctrl
   import asr_pkg::*;
#(
   parameter int unsigned ADDR_W = ASR_ADDR_W,
   parameter int unsigned DATA_W = ASR_DATA_W
)(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              srst,
   // user request
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   // user response
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   // memory pins
   output logic [ADDR_W-1:0]      address_in,
   output logic                   chip_sel_n,
   output logic                   write_en_n,
   output logic                   out_en_n,
   input  wire logic [DATA_W-1:0] data_io_i,
   output logic [DATA_W-1:0]      data_io_o,
   output logic                   data_io_oe
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      // sequencing
      asr_state_t          fsm;
      logic                rdy;
      // read response
      logic                rv;
      logic [DATA_W-1:0]   rd;
      // memory pins, each one a register
      logic [ADDR_W-1:0]   addr;
      logic                cs_n;
      logic                we_n;
      logic                oe_n;
      logic [DATA_W-1:0]   dout;
      logic                doe;
   } asr_cstate_t;

   asr_cstate_t st_reg;
   asr_cstate_t st_next;

   // ************************************************************
   // helpers
   // ************************************************************
   // phase length as loaded into the timer
   // counts come rounded up from the package and are never zero
   function automatic logic [ASR_CNT_W-1:0] asr_phase(input int unsigned cyc);
      return ASR_CNT_W'(cyc);
   endfunction

   // memory deselected and quiet, controller ready for the next request
   function automatic asr_cstate_t asr_release(input asr_cstate_t s);
      asr_cstate_t r;
      r      = s;
      r.fsm  = ASR_IDLE;
      r.rdy  = 1'b1;
      r.cs_n = 1'b1;
      r.we_n = 1'b1;
      r.oe_n = 1'b1;
      r.doe  = 1'b0;
      return r;
   endfunction

   // ************************************************************
   // phase timer
   // ************************************************************
   // kept apart so the sequencer carries no counter of its own;
   // done must not depend on load, or the two would form a loop
   asr_tim_if tif ();

   asr_timer u_timer (
      .clock (clock),
      .srst  (srst),
      .tif   (tif)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next      = st_reg;
      st_next.rv   = 1'b0;
      tif.load     = 1'b0;
      tif.count    = '0;
      unique case (st_reg.fsm)
         ASR_IDLE: begin
            if (req_valid && st_reg.rdy) begin
               st_next.rdy  = 1'b0;
               // address set up with select, never after
               st_next.addr = req_addr;
               st_next.cs_n = 1'b0;
               tif.load     = 1'b1;
               if (req_write) begin
                  // output enable held high so no bus fight during write
                  st_next.fsm  = ASR_WRITE;
                  st_next.we_n = 1'b0;
                  st_next.oe_n = 1'b1;
                  st_next.dout = req_wdata;
                  // drive only after memory released bus from a prior read
                  st_next.doe  = 1'b1;
                  tif.count    = asr_phase(ASR_WR_CYC);
               end else begin
                  st_next.fsm  = ASR_READ;
                  st_next.we_n = 1'b1;
                  st_next.oe_n = 1'b0;
                  st_next.doe  = 1'b0;
                  tif.count    = asr_phase(ASR_RD_CYC);
               end
            end
         end

         ASR_READ: begin
            if (tif.done) begin
               // sample before releasing controls, data still within hold
               st_next.rd   = data_io_i;
               st_next.rv   = 1'b1;
               st_next.cs_n = 1'b1;
               st_next.oe_n = 1'b1;
               st_next.fsm  = ASR_TURN;
               tif.load     = 1'b1;
               tif.count    = asr_phase(ASR_TURN_CYC);
            end
         end

         ASR_WRITE: begin
            if (tif.done) begin
               // strobe and select rise together, ending the overlap
               st_next.we_n = 1'b1;
               st_next.cs_n = 1'b1;
               st_next.fsm  = ASR_RECOV;
               tif.load     = 1'b1;
               // rest of the write cycle, at least one cycle of data hold
               tif.count    = asr_phase(ASR_WC_CYC - ASR_WR_CYC + 1);
            end
         end

         ASR_RECOV: begin
            // data held one more cycle past the write end
            st_next.doe = 1'b0;
            if (tif.done) begin
               st_next = asr_release(st_next);
            end
         end

         ASR_TURN: begin
            // memory drivers may still be floating; nobody drives yet
            if (tif.done) begin
               st_next = asr_release(st_next);
            end
         end

         // codes five to seven are unused; recover to a quiet bus
         default: begin
            st_next = asr_release(st_next);
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   // reset leaves the memory deselected with the bus released
   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg         <= '0;
         st_reg.fsm     <= ASR_IDLE;
         st_reg.rdy     <= 1'b1;
         st_reg.cs_n    <= 1'b1;
         st_reg.we_n    <= 1'b1;
         st_reg.oe_n    <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // pin drivers
   // ************************************************************
   // straight from registers: a glitch on select or strobe of an
   // asynchronous memory could start a stray write
   assign req_ready  = st_reg.rdy;
   assign rsp_valid  = st_reg.rv;
   assign rsp_rdata  = st_reg.rd;
   assign address_in = st_reg.addr;
   assign chip_sel_n = st_reg.cs_n;
   assign write_en_n = st_reg.we_n;
   assign out_en_n   = st_reg.oe_n;
   assign data_io_o  = st_reg.dout;
   assign data_io_oe = st_reg.doe;

endmodule

// [src/asr_pkg.sv]
// asr_pkg: constants and types for the asynchronous static memory controller.
// assumes a 200 MHz clock; all timing counts derive from the fastest grade.
package asr_pkg;

   // ************************************************************
   // geometry
   // ************************************************************
   localparam int unsigned ASR_ADDR_W = 17;
   localparam int unsigned ASR_DATA_W = 8;
   localparam int unsigned ASR_DEPTH  = 131072;

   // ************************************************************
   // timing, fastest grade, in picoseconds, and derived cycle counts
   // ************************************************************
   localparam int unsigned ASR_CLK_PS     = 5000;
   localparam int unsigned ASR_T_RC_PS    = 15000;
   localparam int unsigned ASR_T_AA_PS    = 15000;
   localparam int unsigned ASR_T_WC_PS    = 15000;
   localparam int unsigned ASR_T_CW_PS    = 12000;
   localparam int unsigned ASR_T_AW_PS    = 9000;
   localparam int unsigned ASR_T_DS_PS    = 8000;
   localparam int unsigned ASR_T_HZWE_PS  = 6000;
   localparam int unsigned ASR_T_HZOE_PS  = 6000;

   function automatic int unsigned asr_cyc_up(input int unsigned ps);
      int unsigned c;
      c = (ps + ASR_CLK_PS - 1) / ASR_CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned ASR_RD_CYC   = asr_cyc_up(ASR_T_AA_PS) + 1;
   localparam int unsigned ASR_RC_CYC   = asr_cyc_up(ASR_T_RC_PS);
   localparam int unsigned ASR_WR_CYC   = asr_cyc_up(ASR_T_CW_PS);
   localparam int unsigned ASR_WC_CYC   = asr_cyc_up(ASR_T_WC_PS);
   localparam int unsigned ASR_TURN_CYC = asr_cyc_up(ASR_T_HZOE_PS);
   localparam int unsigned ASR_CNT_W    = 4;

   // ************************************************************
   // state machine
   // ************************************************************
   typedef enum logic [2:0] {
      ASR_IDLE  = 3'b000,
      ASR_READ  = 3'b001,
      ASR_WRITE = 3'b010,
      ASR_RECOV = 3'b011,
      ASR_TURN  = 3'b100
   } asr_state_t;

endpackage

// [src/asr_tim_if.sv]
// asr_tim_if: load and done handshake between the controller and its phase timer.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface asr_tim_if;
   import asr_pkg::*;
   logic                 load;
   logic [ASR_CNT_W-1:0] count;
   logic                 done;
   modport ctrl (output load, output count, input done);
   modport tim  (input load, input count, output done);
endinterface

// [src/asr_timer.sv]
// asr_timer: down counter that times one phase of a memory cycle.
// assumes load is a one-cycle pulse; done is high in the last cycle of the phase.
`timescale 1ns/1ps
module asr_timer
   import asr_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // phase handshake
   asr_tim_if.tim    tif
);

   typedef struct packed {
      logic [ASR_CNT_W-1:0] cnt;
   } asr_tstate_t;

   asr_tstate_t st_reg;
   asr_tstate_t st_next;

   always_comb begin
      st_next = st_reg;
      if (tif.load) begin
         st_next.cnt = tif.count;
      end else if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // last cycle of a phase is when one count remains; a plain decode of the
   // count, since the controller raises load from done in the same cycle
   assign tif.done = (st_reg.cnt == 4'h1);

endmodule

// [tb/asr_ctrl_chk.sv]
// asr_ctrl_chk: pin protocol assertions for the memory controller.
// assumes binding to asr_ctrl, one clock domain.
`timescale 1ns/1ps
module asr_ctrl_chk
   import asr_pkg::*;
#(
   parameter int unsigned ADDR_W = ASR_ADDR_W,
   parameter int unsigned DATA_W = ASR_DATA_W
)(
   // clock and reset
   input wire logic              clock,
   input wire logic              srst,
   // user side
   input wire logic              req_valid,
   input wire logic              req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic              req_ready,
   input wire logic              rsp_valid,
   input wire logic [DATA_W-1:0] rsp_rdata,
   // memory pins
   input wire logic [ADDR_W-1:0] address_in,
   input wire logic              chip_sel_n,
   input wire logic              write_en_n,
   input wire logic              out_en_n,
   input wire logic [DATA_W-1:0] data_io_i,
   input wire logic [DATA_W-1:0] data_io_o,
   input wire logic              data_io_oe
);
   // *****
   // cycle shapes
   // *****
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence rd_hold;
      (!chip_sel_n && !out_en_n && write_en_n) [*4];
   endsequence
   sequence wr_hold;
      (!chip_sel_n && !write_en_n && out_en_n && data_io_oe) [*3];
   endsequence
   read_cycle_a: assert property (req_valid && req_ready && !req_write
      |=> rd_hold ##1 (chip_sel_n && rsp_valid)) else $error("read cycle shape");
   write_cycle_a: assert property (req_valid && req_ready && req_write
      |=> wr_hold ##1 (chip_sel_n && write_en_n)) else $error("write cycle shape");
   acc_addr_a: assert property (req_valid && req_ready
      |=> address_in == $past(req_addr)) else $error("address not presented");
   wr_data_a: assert property (req_valid && req_ready && req_write
      |=> data_io_o == $past(req_wdata)) else $error("write data wrong");
   no_fight_a: assert property (data_io_oe |-> out_en_n) else $error("bus contention");
   strobe_sel_a: assert property (!write_en_n |-> !chip_sel_n) else $error("strobe off");
   addr_stable_a: assert property (!chip_sel_n && $past(!chip_sel_n)
      |-> $stable(address_in)) else $error("address moved");
   rsp_data_a: assert property (rsp_valid |-> $past(!out_en_n)
      && rsp_rdata == $past(data_io_i)) else $error("read byte wrong");
   wr_release_a: assert property (req_valid && req_ready && req_write
      |=> wr_hold ##1 (chip_sel_n && data_io_oe) ##1 !data_io_oe) else $error("write release");
   turn_gap_a: assert property (rsp_valid
      |-> !req_ready ##1 (!req_ready && chip_sel_n) ##1 req_ready) else $error("turnaround short");
   reset_idle_a: assert property ($fell(srst) |-> chip_sel_n && out_en_n
      && write_en_n && !data_io_oe && req_ready) else $error("not idle after reset");
endmodule
bind asr_ctrl asr_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clock(clock),
   .srst(srst), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
   .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .rsp_rdata(rsp_rdata), .address_in(address_in), .chip_sel_n(chip_sel_n),
   .write_en_n(write_en_n), .out_en_n(out_en_n), .data_io_i(data_io_i),
   .data_io_o(data_io_o), .data_io_oe(data_io_oe));

// [tb/asr_sram_model.sv]
// asr_sram_model: behavioural 128k x 8 static memory at its pins.
// assumes dq_i is the resolved data line; no clock, no reset.
`timescale 1ns/1ps
module asr_sram_model
   import asr_pkg::*;
#(
   parameter int ACC_NS = 14
)(
   // control and address
   input wire logic [ASR_ADDR_W-1:0] address_in,
   input wire logic                  chip_sel_n,
   input wire logic                  write_en_n,
   input wire logic                  out_en_n,
   // data line
   input wire logic [ASR_DATA_W-1:0] dq_i,
   output logic [ASR_DATA_W-1:0]     dq_o,
   output logic                      dq_oe
);
   // *****
   // array
   // *****
   logic [ASR_DATA_W-1:0] mem [ASR_DEPTH];
   wire                   standby = chip_sel_n;
   // overlap write: last value before the first rising control stays
   always @(chip_sel_n or write_en_n or address_in or dq_i)
      if (!chip_sel_n && !write_en_n) mem[address_in] = dq_i;
   // slow access; old byte lingers after an address change
   assign #(ACC_NS) dq_o = mem[address_in];
   assign dq_oe = !standby && write_en_n && !out_en_n;
endmodule

// [tb/asr_ctrl_tb.sv]
// asr_ctrl_tb: self-checking bench, controller against the memory model.
// assumes asr_sram_model and the bound checker are compiled first.
`timescale 1ns/1ps
module asr_ctrl_tb;
   import asr_pkg::*;
   logic                  clock = 0, srst = 1, req_valid = 0, req_write = 0;
   logic [ASR_ADDR_W-1:0] req_addr = '0, address_in;
   logic [ASR_DATA_W-1:0] req_wdata = '0, rsp_rdata, data_io_o, mem_o, float_q = 8'h00;
   logic                  req_ready, rsp_valid, chip_sel_n, write_en_n, out_en_n;
   logic                  data_io_oe, mem_oe;
   logic [16:0]           adr [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
   int                    error_cnt = 0, tests_run = 0;
   // released line shows the inverse of its last level
   wire [7:0] bus = data_io_oe ? data_io_o : (mem_oe ? mem_o : float_q);
   always @(posedge clock) float_q <= ~bus;
   initial forever #2.5 clock = ~clock;
   asr_ctrl dut (.clock(clock), .srst(srst), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .address_in(address_in),
      .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
      .data_io_i(bus), .data_io_o(data_io_o), .data_io_oe(data_io_oe));
   asr_sram_model mem (.address_in(address_in), .chip_sel_n(chip_sel_n),
      .write_en_n(write_en_n), .out_en_n(out_en_n), .dq_i(bus), .dq_o(mem_o), .dq_oe(mem_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic issue(input logic w, input logic [16:0] a, input logic [7:0] d);
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge clock); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
   endtask
   task automatic write_scn(input logic [16:0] a, input logic [7:0] d);
      int n;
      issue(1'b1, a, d);
      n = 0;
      do begin @(posedge clock); n++; end while (req_ready !== 1'b1 && n < 12);
      // write cycle, then one cycle of data hold before ready returns
      check(n, ASR_WC_CYC + 2);
   endtask
   task automatic read_scn(input logic [16:0] a, input logic [7:0] exp);
      int n;
      issue(1'b0, a, 8'h00);
      n = 0;
      do begin @(posedge clock); n++; end while (rsp_valid !== 1'b1 && n < 12);
      check(n, 5);
      check(rsp_rdata, exp);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      check({chip_sel_n, out_en_n, write_en_n, data_io_oe, req_ready}, 5'h1D);
      // boundary and alternating addresses catch aliasing
      for (int i = 0; i < 4; i++) write_scn(adr[i], 8'h3C + 8'(i * 8'h41));
      for (int i = 3; i >= 0; i--) read_scn(adr[i], 8'h3C + 8'(i * 8'h41));
      write_scn(adr[0], 8'hA5);
      write_scn(adr[0], 8'h5A);
      read_scn(adr[0], 8'h5A);
      read_scn(adr[1], 8'h7D);
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge clock);
      error_cnt++;
      end_of_test();
   end
endmodule
